//--- cscr_regs.v
// status and calibration register bank behind a serial management link
// Notes on behaviour
// - sixteen-bit status summary with documented bit layout
// - output overvoltage sets bit 7, host clears
// - overcurrent fault bit 7, warning bit 5
// - overtemperature fault bit 7, warning bit 6
// - bad command, bad data, checksum failure flags
// - read-only revision byte reports 1.2 twice
// - protect enable in device type bit 1
// - six-bit module name in bits 7:2
// - gain writes only within limits, protect locks
// - output offset needs exponent -12, protect locks
// - input and current offsets need exponent -3
// - read-only sixteen-bit firmware revision word
`timescale 1ns/1ps
`default_nettype none
`include "cscr_defines.vh"

module cscr_regs #(
   parameter [6:0]  DEV_ADDR    = 7'h58,
   parameter [5:0]  MODULE_NAME = 6'b101010,
   parameter [15:0] FW_REVISION = 16'h1200   // arbitrary value
) (
   // clock and reset
   input  wire        CLK,
   input  wire        RST_N,
   input  wire        CE,
   // management link
   input  wire        SCL,
   input  wire        SDA_IN,
   output reg         SDA_OUT,
   output reg         SDA_OE,
   // converter conditions, same clock domain
   input  wire        OV_FAULT,
   input  wire        OC_FAULT,
   input  wire        OC_WARN,
   input  wire        OT_FAULT,
   input  wire        OT_WARN,
   input  wire        VIN_UV_FAULT,
   input  wire        OUTPUT_OFF,
   input  wire        POWER_GOOD,
   // measured values
   input  wire [15:0] VIN_VALUE,
   input  wire [15:0] VOUT_VALUE,
   input  wire [15:0] IOUT_VALUE,
   input  wire [15:0] TEMP_VALUE,
   // calibration outputs
   output reg         WRITE_PROTECT,
   output reg  [15:0] VOUT_GAIN,
   output reg  [15:0] VOUT_OFFSET,
   output reg  [15:0] VIN_GAIN,
   output reg  [15:0] VIN_OFFSET,
   output reg  [15:0] IOUT_GAIN,
   output reg  [15:0] IOUT_OFFSET
);

   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_ADDR  = 3'd1;
   localparam [2:0] S_ACKA  = 3'd2;
   localparam [2:0] S_RX    = 3'd3;
   localparam [2:0] S_ACKR  = 3'd4;
   localparam [2:0] S_TX    = 3'd5;
   localparam [2:0] S_ACKT  = 3'd6;

   // link synchronisers
   reg        scl_s1;
   reg        scl_s2;
   reg        scl_s3;
   reg        sda_s1;
   reg        sda_s2;
   reg        sda_s3;

   // link engine
   reg  [2:0] state;
   reg  [7:0] shreg;
   reg  [3:0] bitcnt;
   reg  [2:0] idx;
   reg  [1:0] tx_idx;
   reg        rw;
   reg        nak;
   reg        wr_seen;
   reg  [7:0] cmd;
   reg [15:0] wdata;
   reg  [7:0] crc;
   reg  [7:0] dev_low;

   // status
   reg  [7:0] st_vout;
   reg  [7:0] st_iout;
   reg  [7:0] st_temp;
   reg  [7:0] st_comm;
   reg  [7:0] clr_vout;
   reg  [7:0] clr_iout;
   reg  [7:0] clr_temp;
   reg  [7:0] clr_comm;
   reg  [7:0] set_comm;

   reg        cmd_known;
   reg        cmd_word;
   reg [15:0] rd_word;
   reg  [7:0] tx_byte_next;
   wire [15:0] status_word;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;
   wire [2:0] len;
   wire [2:0] need;
   wire       len_bad;
   wire       pec_bad;
   wire       wr_ok;
   wire       in_gain;

   function [7:0] crc_step;
      input [7:0] c;
      input       b;
      begin
         crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? 8'h07 : 8'h00);
      end
   endfunction

   assign scl_rise  = scl_s2 & ~scl_s3;
   assign scl_fall  = ~scl_s2 & scl_s3;
   assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // summary is live OR of the detail bytes plus the undervoltage, power-good and output-off inputs
   assign status_word = {|st_vout, |st_iout, VIN_UV_FAULT, 1'b0,
                         ~POWER_GOOD, 3'b000,
                         1'b0, OUTPUT_OFF, st_vout[7], st_iout[7],
                         VIN_UV_FAULT, |st_temp, |st_comm, 1'b0};

   // command decode and read data
   always @* begin
      cmd_known = 1'b1;
      cmd_word  = 1'b1;
      rd_word   = 16'h0000;
      case (cmd)
         `CSCR_CMD_STATUS_WORD: rd_word = status_word;
         `CSCR_CMD_OUTPUT_VOLTAGE_STATUS: begin
            rd_word  = {8'h00, st_vout};
            cmd_word = 1'b0;
         end
         `CSCR_CMD_OUTPUT_CURRENT_STATUS: begin
            rd_word  = {8'h00, st_iout};
            cmd_word = 1'b0;
         end
         `CSCR_CMD_STATUS_TEMP: begin
            rd_word  = {8'h00, st_temp};
            cmd_word = 1'b0;
         end
         `CSCR_CMD_STATUS_COMM: begin
            rd_word  = {8'h00, st_comm};
            cmd_word = 1'b0;
         end
         `CSCR_CMD_INPUT_VOLTAGE_READBACK:    rd_word = VIN_VALUE;
         `CSCR_CMD_OUTPUT_VOLTAGE_READBACK:   rd_word = VOUT_VALUE;
         `CSCR_CMD_OUTPUT_CURRENT_READBACK:   rd_word = IOUT_VALUE;
         `CSCR_CMD_READ_TEMP:   rd_word = TEMP_VALUE;
         `CSCR_CMD_PROTO_REV: begin
            rd_word  = {8'h00, `CSCR_PROTO_REV};
            cmd_word = 1'b0;
         end
         `CSCR_CMD_DEV_TYPE:    rd_word = {8'h00, dev_low};
         `CSCR_CMD_VOUT_GAIN:   rd_word = VOUT_GAIN;
         `CSCR_CMD_VOUT_OFFSET: rd_word = VOUT_OFFSET;
         `CSCR_CMD_VIN_GAIN:    rd_word = VIN_GAIN;
         `CSCR_CMD_VIN_OFFSET:  rd_word = VIN_OFFSET;
         `CSCR_CMD_IOUT_GAIN:   rd_word = IOUT_GAIN;
         `CSCR_CMD_IOUT_OFFSET: rd_word = IOUT_OFFSET;
         `CSCR_CMD_FW_REV:      rd_word = FW_REVISION;
         default: begin
            cmd_known = 1'b0;
            rd_word   = 16'hFFFF;
         end
      endcase
   end

   // write length checks at stop
   assign len     = idx - 3'd1;
   assign need    = cmd_word ? 3'd2 : 3'd1;
   assign pec_bad = (len == need + 3'd1) && (crc != 8'h00);
   assign len_bad = (len != need) && (len != need + 3'd1);
   assign wr_ok   = cmd_known && !len_bad && !pec_bad;
   assign in_gain = (wdata >= `CSCR_GAIN_MIN) &&
                    (wdata <= `CSCR_GAIN_MAX);

   // link engine and register writes
   always @(posedge CLK) begin
      if (!RST_N) begin
         scl_s1        <= 1'b1;
         scl_s2        <= 1'b1;
         scl_s3        <= 1'b1;
         sda_s1        <= 1'b1;
         sda_s2        <= 1'b1;
         sda_s3        <= 1'b1;
         state         <= S_IDLE;
         shreg         <= 8'h00;
         bitcnt        <= 4'h0;
         idx           <= 3'd0;
         tx_idx        <= 2'd0;
         rw            <= 1'b0;
         nak           <= 1'b0;
         wr_seen       <= 1'b0;
         cmd           <= 8'h00;
         wdata         <= 16'h0000;
         crc           <= 8'h00;
         SDA_OUT       <= 1'b0;
         SDA_OE        <= 1'b0;
         dev_low       <= {MODULE_NAME, 2'b10};  // protect on
         WRITE_PROTECT <= 1'b1;
         VOUT_GAIN     <= `CSCR_GAIN_RESET;
         VIN_GAIN      <= `CSCR_GAIN_RESET;
         IOUT_GAIN     <= `CSCR_GAIN_RESET;
         VOUT_OFFSET   <= `CSCR_VOUT_OFFSET_RESET;
         VIN_OFFSET    <= `CSCR_LIN_OFFSET_RESET;
         IOUT_OFFSET   <= `CSCR_LIN_OFFSET_RESET;
         clr_vout      <= 8'h00;
         clr_iout      <= 8'h00;
         clr_temp      <= 8'h00;
         clr_comm      <= 8'h00;
         set_comm      <= 8'h00;
      end else if (CE) begin
         scl_s1   <= SCL;
         scl_s2   <= scl_s1;
         scl_s3   <= scl_s2;
         sda_s1   <= SDA_IN;
         sda_s2   <= sda_s1;
         sda_s3   <= sda_s2;
         clr_vout <= 8'h00;
         clr_iout <= 8'h00;
         clr_temp <= 8'h00;
         clr_comm <= 8'h00;
         set_comm <= 8'h00;
         WRITE_PROTECT <= dev_low[`CSCR_DEV_WP_BIT];
         // received bits enter the checksum at the following fall, so the
         // lone rise before a repeated start or stop stays out of it
         if (scl_rise && state == S_TX)
            crc <= crc_step(crc, sda_s2);
         else if (scl_fall && bitcnt != 4'h0 &&
                  (state == S_ADDR || state == S_RX))
            crc <= crc_step(crc, shreg[0]);
         if (start_det) begin
            state  <= S_ADDR;
            bitcnt <= 4'h0;
            SDA_OE <= 1'b0;
         end else if (stop_det) begin
            state   <= S_IDLE;
            SDA_OE  <= 1'b0;
            crc     <= 8'h00;
            idx     <= 3'd0;
            wr_seen <= 1'b0;
            if (wr_seen && idx > 3'd1 && cmd_known) begin
               set_comm[`CSCR_COMM_PEC_FAIL] <= pec_bad;
               set_comm[`CSCR_COMM_BAD_DATA] <= len_bad;
            end
            if (wr_seen && idx > 3'd1 && wr_ok) begin
               case (cmd)
                  // writing ones clears status bits
                  `CSCR_CMD_OUTPUT_VOLTAGE_STATUS: clr_vout <= wdata[7:0];
                  `CSCR_CMD_OUTPUT_CURRENT_STATUS: clr_iout <= wdata[7:0];
                  `CSCR_CMD_STATUS_TEMP: clr_temp <= wdata[7:0];
                  `CSCR_CMD_STATUS_COMM: clr_comm <= wdata[7:0];
                  `CSCR_CMD_DEV_TYPE:
                     dev_low <= (wdata[7:0] & `CSCR_DEV_WR_MASK);
                  `CSCR_CMD_VOUT_GAIN:
                     if (!WRITE_PROTECT) begin
                        if (in_gain)
                           VOUT_GAIN <= wdata;
                        else
                           set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
                     end
                  `CSCR_CMD_VIN_GAIN:
                     if (!WRITE_PROTECT) begin
                        if (in_gain)
                           VIN_GAIN <= wdata;
                        else
                           set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
                     end
                  `CSCR_CMD_IOUT_GAIN:
                     if (!WRITE_PROTECT) begin
                        if (in_gain)
                           IOUT_GAIN <= wdata;
                        else
                           set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
                     end
                  `CSCR_CMD_VOUT_OFFSET:
                     if (!WRITE_PROTECT) begin
                        if (wdata[15:11] == `CSCR_EXP_M12)
                           VOUT_OFFSET <= wdata;
                        else
                           set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
                     end
                  `CSCR_CMD_VIN_OFFSET:
                     if (!WRITE_PROTECT) begin
                        if (wdata[15:11] == `CSCR_EXP_M3)
                           VIN_OFFSET <= wdata;
                        else
                           set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
                     end
                  `CSCR_CMD_IOUT_OFFSET:
                     if (!WRITE_PROTECT) begin
                        if (wdata[15:11] == `CSCR_EXP_M3)
                           IOUT_OFFSET <= wdata;
                        else
                           set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
                     end
                  // read-only commands
                  default: set_comm[`CSCR_COMM_BAD_DATA] <= 1'b1;
               endcase
            end
         end else begin
            case (state)
               S_IDLE: SDA_OE <= 1'b0;
               S_ADDR: begin
                  if (scl_rise) begin
                     shreg  <= {shreg[6:0], sda_s2};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     if (shreg[7:1] == DEV_ADDR) begin
                        rw     <= shreg[0];
                        SDA_OE <= 1'b1;
                        state  <= S_ACKA;
                     end else begin
                        state  <= S_IDLE;
                     end
                  end
               end
               S_ACKA: begin
                  if (scl_fall) begin
                     bitcnt <= 4'h0;
                     tx_idx <= 2'd0;
                     if (rw) begin
                        SDA_OE <= ~rd_word[7];
                        shreg  <= {rd_word[6:0], 1'b1};
                        bitcnt <= 4'h1;
                        state  <= S_TX;
                     end else begin
                        SDA_OE <= 1'b0;
                        state  <= S_RX;
                     end
                  end
               end
               S_RX: begin
                  if (scl_rise) begin
                     shreg  <= {shreg[6:0], sda_s2};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     wr_seen <= 1'b1;
                     if (idx != 3'd7)
                        idx <= idx + 3'd1;
                     if (idx == 3'd0) begin
                        cmd   <= shreg;
                        wdata <= 16'h0000;
                     end else if (idx == 3'd1) begin
                        wdata[7:0] <= shreg;
                     end else if (idx == 3'd2 && cmd_word) begin
                        wdata[15:8] <= shreg;
                     end
                     SDA_OE <= 1'b1;
                     state  <= S_ACKR;
                  end
               end
               S_ACKR: begin
                  if (scl_fall) begin
                     if (idx == 3'd1 && !cmd_known)
                        set_comm[`CSCR_COMM_BAD_CMD] <= 1'b1;
                     SDA_OE <= 1'b0;
                     bitcnt <= 4'h0;
                     state  <= S_RX;
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        SDA_OE <= 1'b0;
                        state  <= S_ACKT;
                     end else begin
                        SDA_OE <= ~shreg[7];
                        shreg  <= {shreg[6:0], 1'b1};
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               S_ACKT: begin
                  if (scl_rise) begin
                     nak <= sda_s2;
                  end else if (scl_fall) begin
                     if (nak) begin
                        state <= S_IDLE;
                     end else begin
                        tx_idx <= tx_idx + 2'd1;
                        state  <= S_TX;
                        bitcnt <= 4'h1;
                        SDA_OE <= ~tx_byte_next[7];
                        shreg  <= {tx_byte_next[6:0], 1'b1};
                     end
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // next byte during a read, one ahead of tx_idx
   always @* begin
      if (tx_idx == 2'd0 && cmd_word)
         tx_byte_next = rd_word[15:8];
      else if (tx_idx == {1'b0, cmd_word})
         tx_byte_next = crc;
      else
         tx_byte_next = 8'hFF;
   end

   // sticky status, a set outranks a clear in the same cycle
   always @(posedge CLK) begin
      if (!RST_N) begin
         st_vout <= 8'h00;
         st_iout <= 8'h00;
         st_temp <= 8'h00;
         st_comm <= 8'h00;
      end else if (CE) begin
         st_vout <= ((st_vout & ~clr_vout) | {OV_FAULT, 7'h00})
                    & `CSCR_VOUT_MASK;
         st_iout <= ((st_iout & ~clr_iout) |
                     {OC_FAULT, 1'b0, OC_WARN, 5'h00})
                    & `CSCR_IOUT_MASK;
         st_temp <= ((st_temp & ~clr_temp) | {OT_FAULT, OT_WARN, 6'h00})
                    & `CSCR_TEMP_MASK;
         st_comm <= ((st_comm & ~clr_comm) | set_comm)
                    & `CSCR_COMM_MASK;
      end
   end

endmodule // cscr_regs

`default_nettype wire

//--- cscr_defines.vh
// constants for the converter status and calibration register bank
`ifndef CSCR_DEFINES_VH
`define CSCR_DEFINES_VH

// command codes
`define CSCR_CMD_STATUS_WORD    8'h79
`define CSCR_CMD_OUTPUT_VOLTAGE_STATUS    8'h7A
`define CSCR_CMD_OUTPUT_CURRENT_STATUS    8'h7B
`define CSCR_CMD_STATUS_TEMP    8'h7D
`define CSCR_CMD_STATUS_COMM    8'h7E
`define CSCR_CMD_INPUT_VOLTAGE_READBACK       8'h88
`define CSCR_CMD_OUTPUT_VOLTAGE_READBACK      8'h8B
`define CSCR_CMD_OUTPUT_CURRENT_READBACK      8'h8C
`define CSCR_CMD_READ_TEMP      8'h8D
`define CSCR_CMD_PROTO_REV      8'h98
`define CSCR_CMD_DEV_TYPE       8'hD0
`define CSCR_CMD_VOUT_GAIN      8'hD1
`define CSCR_CMD_VOUT_OFFSET    8'hD2
`define CSCR_CMD_VIN_GAIN       8'hD3
`define CSCR_CMD_VIN_OFFSET     8'hD4
`define CSCR_CMD_IOUT_GAIN      8'hD6
`define CSCR_CMD_IOUT_OFFSET    8'hD7
`define CSCR_CMD_FW_REV         8'hDB

// implemented bits of each status byte
`define CSCR_VOUT_MASK          8'h80
`define CSCR_IOUT_MASK          8'hA0
`define CSCR_TEMP_MASK          8'hC0
`define CSCR_COMM_MASK          8'hE0
`define CSCR_COMM_BAD_CMD       7
`define CSCR_COMM_BAD_DATA      6
`define CSCR_COMM_PEC_FAIL      5

// protocol revision 1.2 / 1.2, bit 4 unused
`define CSCR_PROTO_REV          8'h42

// device type: name in 7:2, protect enable in 1
`define CSCR_DEV_TYPE_RESET     8'hAA
`define CSCR_DEV_WP_BIT         1
`define CSCR_DEV_WR_MASK        8'hFE

// calibration limits and reset values
`define CSCR_GAIN_RESET         16'h2000
`define CSCR_GAIN_MIN           16'h1999
`define CSCR_GAIN_MAX           16'h2666
`define CSCR_EXP_M12            5'h14
`define CSCR_EXP_M3             5'h1D
`define CSCR_VOUT_OFFSET_RESET  16'hA000
`define CSCR_LIN_OFFSET_RESET   16'hE800

`endif

//--- cscr_regs_properties.sv
// port-level checks on the status and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module cscr_regs_props (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        CE,
   // management link
   input wire logic        SCL,
   input wire logic        SDA_IN,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE,
   // calibration outputs
   input wire logic        WRITE_PROTECT,
   input wire logic [15:0] VOUT_GAIN,
   input wire logic [15:0] VOUT_OFFSET,
   input wire logic [15:0] VIN_GAIN,
   input wire logic [15:0] VIN_OFFSET,
   input wire logic [15:0] IOUT_GAIN,
   input wire logic [15:0] IOUT_OFFSET
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   wire logic [95:0] cal_all = {VOUT_GAIN, VOUT_OFFSET, VIN_GAIN,
                                VIN_OFFSET, IOUT_GAIN, IOUT_OFFSET};
   reset_values_a: assert property (
      $rose(RST_N) |-> WRITE_PROTECT &&
      {VOUT_GAIN, VIN_GAIN, IOUT_GAIN} == {3{16'h2000}})
      else $error("calibration reset values wrong");
   vout_gain_range_a: assert property (
      VOUT_GAIN >= 16'h1999 && VOUT_GAIN <= 16'h2666)
      else $error("vout gain out of range");
   gain_range_a: assert property (
      VIN_GAIN inside {[16'h1999:16'h2666]} &&
      IOUT_GAIN inside {[16'h1999:16'h2666]})
      else $error("gain out of range");
   vout_exp_a: assert property (VOUT_OFFSET[15:11] == 5'h14)
      else $error("vout offset exponent wrong");
   lin_exp_a: assert property (
      VIN_OFFSET[15:11] == 5'h1D && IOUT_OFFSET[15:11] == 5'h1D)
      else $error("offset exponent wrong");
   protect_lock_a: assert property (
      WRITE_PROTECT && $past(WRITE_PROTECT) |-> $stable(cal_all))
      else $error("calibration changed while protected");
   cal_commit_a: assert property (
      $changed(cal_all) |-> SCL && SDA_IN && $past(SCL, 3))
      else $error("calibration changed outside stop");
   protect_commit_a: assert property (
      $changed(WRITE_PROTECT) |-> SCL && SDA_IN)
      else $error("protect changed outside stop");
   freeze_a: assert property (!CE |=> $stable(cal_all) && $stable(SDA_OE))
      else $error("state moved with clock enable low");
   oe_change_a: assert property ($changed(SDA_OE) |-> !SCL)
      else $error("data line changed while clock high");
   sda_zero_a: assert property (SDA_OUT == 1'b0)
      else $error("data output not low");
   cover property ($fell(WRITE_PROTECT));
   cover property ($changed(VOUT_OFFSET));
   cover property ($rose(SDA_OE));
endmodule // cscr_regs_props
bind cscr_regs cscr_regs_props i_cscr_regs_props (
   .CLK(CLK), .RST_N(RST_N), .CE(CE), .SCL(SCL), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WRITE_PROTECT(WRITE_PROTECT),
   .VOUT_GAIN(VOUT_GAIN), .VOUT_OFFSET(VOUT_OFFSET),
   .VIN_GAIN(VIN_GAIN), .VIN_OFFSET(VIN_OFFSET),
   .IOUT_GAIN(IOUT_GAIN), .IOUT_OFFSET(IOUT_OFFSET));
`default_nettype wire

//--- cscr_host.sv
// host model: drives frames on the management link
`timescale 1ns/1ps
`default_nettype none
module cscr_host #(
   parameter logic [6:0] ADDR = 7'h58
) (
   // clock and wire level
   input  wire logic clk,
   input  wire logic sda,
   // link drive, pull high = data line low
   output var  logic scl,
   output var  logic pull
);
   logic [7:0] crc;
   initial begin
      scl = 1'b1;
      pull = 1'b0;
      crc = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic crc_add(input logic [7:0] b);
      crc = crc ^ b;
      repeat (8) crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h07 : 8'h00);
   endtask
   // one bit: 6 cycles low, 2 high, line taken at the rise
   task automatic bit_x(input logic b, output logic s);
      scl <= 1'b0;
      tick(2);
      pull <= !b;
      tick(4);
      s = sda;
      scl <= 1'b1;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic last,
                       output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], s);
         rx[i] = s;
      end
      bit_x(last, s);
      ack = !s;
      crc_add(rx);
   endtask
   task automatic start(input logic rep);
      if (rep) begin
         scl <= 1'b0;
         tick(2);
         pull <= 1'b0;
         tick(4);
         scl <= 1'b1;
         tick(4);
      end else begin
         crc = 8'h00;
      end
      pull <= 1'b1;
      tick(4);
   endtask
   task automatic stop();
      scl <= 1'b0;
      tick(2);
      pull <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      pull <= 1'b0;
      tick(12);
   endtask
   // pec: 0 none, 1 good, 2 corrupted
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
                     input int n, input int pec, output logic ok);
      logic [7:0] r;
      logic       a;
      start(1'b0);
      xfer({ADDR, 1'b0}, 1'b1, r, ok);
      xfer(cmd, 1'b1, r, a);
      ok = ok & a;
      for (int i = 0; i < n; i++) begin
         xfer(d[8*i +: 8], 1'b1, r, a);
         ok = ok & a;
      end
      if (pec != 0) xfer(crc ^ 8'(pec - 1), 1'b1, r, a);
      stop();
   endtask
   task automatic rd(input logic [7:0] cmd, input int n,
                     output logic [15:0] d);
      logic [7:0] r;
      logic       a;
      d = 16'h0000;
      start(1'b0);
      xfer({ADDR, 1'b0}, 1'b1, r, a);
      xfer(cmd, 1'b1, r, a);
      start(1'b1);
      xfer({ADDR, 1'b1}, 1'b1, r, a);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, r, a);
         d[8*i +: 8] = r;
      end
      stop();
   endtask
endmodule // cscr_host
`default_nettype wire

//--- cscr_regs_tb.sv
// self-checking bench for the status and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module cscr_regs_tb;
   localparam logic [15:0] FW = 16'h3A5C;  // arbitrary value
   localparam logic [5:0]  NAME = 6'b100110;
   logic        clk, rst_n, ce, scl, pull, sda_out, sda_oe, wp;
   logic        ovf, ocf, ocw, otf, otw, uv, off, pg;
   logic [15:0] vin, vout, iout, temp;
   logic [15:0] vo_gain, vo_off, vi_gain, vi_off, io_gain, io_off;
   int          bad_count, n_tests;
   wire logic   sda = !(pull || sda_oe);
   always #5 clk = ~clk;
   cscr_regs #(.MODULE_NAME(NAME), .FW_REVISION(FW)) i_cscr_regs (
      .CLK(clk), .RST_N(rst_n), .CE(ce), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .OV_FAULT(ovf),
      .OC_FAULT(ocf), .OC_WARN(ocw), .OT_FAULT(otf), .OT_WARN(otw),
      .VIN_UV_FAULT(uv), .OUTPUT_OFF(off), .POWER_GOOD(pg),
      .VIN_VALUE(vin), .VOUT_VALUE(vout), .IOUT_VALUE(iout),
      .TEMP_VALUE(temp), .WRITE_PROTECT(wp), .VOUT_GAIN(vo_gain),
      .VOUT_OFFSET(vo_off), .VIN_GAIN(vi_gain), .VIN_OFFSET(vi_off),
      .IOUT_GAIN(io_gain), .IOUT_OFFSET(io_off));
   cscr_host i_cscr_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic w(input logic [7:0] c, input logic [15:0] d,
                    input int n, input int pec = 0);
      logic ok;
      i_cscr_host.wr(c, d, n, pec, ok);
      chk("ack", 16'h0001, {15'h0, ok});
   endtask
   task automatic r(input string nm, input logic [7:0] c, input int n,
                    input logic [15:0] e);
      logic [15:0] d;
      i_cscr_host.rd(c, n, d);
      chk(nm, e, d);
   endtask
   task automatic t_ident();
      logic [7:0]  cmd [4] = '{8'h88, 8'h8B, 8'h8C, 8'h8D};
      logic [15:0] v [4];
      v = '{vin, vout, iout, temp};
      r("revision", 8'h98, 1, 16'h0042);
      r("firmware", 8'hDB, 2, FW);
      r("device type", 8'hD0, 2, {8'h00, NAME, 2'b10});
      chk("protect", 16'h0001, {15'h0, wp});
      for (int i = 0; i < 4; i++) r("readback", cmd[i], 2, v[i]);
      ce <= 1'b0;
      tick(3);
      ce <= 1'b1;
      tick(3);
      $display("t_ident done");
   endtask
   task automatic t_cal();
      w(8'hD1, 16'h2100, 2);
      chk("locked gain", 16'h2000, vo_gain);
      w(8'hD0, {8'h55, NAME, 2'b01}, 2);
      r("device type", 8'hD0, 2, {8'h00, NAME, 2'b00});
      chk("protect", 16'h0000, {15'h0, wp});
      w(8'hD1, 16'h2666, 2);
      chk("vout gain", 16'h2666, vo_gain);
      w(8'hD3, 16'h1999, 2);
      chk("vin gain", 16'h1999, vi_gain);
      w(8'hD6, 16'h2667, 2);
      w(8'hD6, 16'h1998, 2);
      chk("iout gain", 16'h2000, io_gain);
      w(8'hD6, 16'h2200, 2, 1);
      chk("gain good pec", 16'h2200, io_gain);
      w(8'hD6, 16'h2300, 2, 2);
      chk("gain bad pec", 16'h2200, io_gain);
      r("comm", 8'h7E, 1, 16'h0060);
      w(8'h7E, 16'h00FF, 1);
      r("comm cleared", 8'h7E, 1, 16'h0000);
      $display("t_cal done");
   endtask
   task automatic t_off();
      w(8'hD2, 16'hA123, 2);
      w(8'hD2, 16'hE123, 2);
      chk("vout offset", 16'hA123, vo_off);
      w(8'hD4, 16'hE805, 2);
      w(8'hD7, 16'hA005, 2);
      chk("vin offset", 16'hE805, vi_off);
      chk("iout offset", 16'hE800, io_off);
      w(8'hD0, {8'h00, NAME, 2'b10}, 2);
      w(8'hD2, 16'hA777, 2);
      w(8'hD4, 16'hEFFF, 2);
      chk("locked offset", 16'hA123, vo_off);
      chk("locked offset", 16'hE805, vi_off);
      w(8'h7E, 16'h00FF, 1);
      $display("t_off done");
   endtask
   task automatic t_comm();
      w(8'h55, 16'h0000, 1);
      w(8'h98, 16'h0043, 1);
      w(8'hD0, 16'h0000, 1);
      r("comm", 8'h7E, 1, 16'h00C0);
      r("device type", 8'hD0, 2, {8'h00, NAME, 2'b10});
      r("revision", 8'h98, 1, 16'h0042);
      w(8'h7E, 16'h00C0, 1);
      r("comm cleared", 8'h7E, 1, 16'h0000);
      $display("t_comm done");
   endtask
   task automatic t_stat();
      {ovf, ocf, ocw, otf, otw, uv, off, pg} <= 8'hFE;
      tick(4);
      {ovf, ocf, ocw, otf, otw} <= 5'h00;
      tick(4);
      r("vout status", 8'h7A, 1, 16'h0080);
      r("iout status", 8'h7B, 1, 16'h00A0);
      r("temp status", 8'h7D, 1, 16'h00C0);
      r("summary", 8'h79, 2, 16'hE87C);
      ovf <= 1'b1;
      w(8'h7A, 16'h00FF, 1);
      w(8'h7B, 16'h00FF, 1);
      w(8'h7D, 16'h00FF, 1);
      r("vout held", 8'h7A, 1, 16'h0080);
      r("iout cleared", 8'h7B, 1, 16'h0000);
      r("temp cleared", 8'h7D, 1, 16'h0000);
      {ovf, uv, off, pg} <= 4'h1;
      w(8'h7A, 16'h0080, 1);
      r("vout cleared", 8'h7A, 1, 16'h0000);
      r("summary clear", 8'h79, 2, 16'h0000);
      $display("t_stat done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      {ovf, ocf, ocw, otf, otw, uv, off} = 7'h00;
      pg = 1'b1;
      vin = 16'h1234;
      vout = 16'h5678;
      iout = 16'h9ABC;
      temp = 16'hDEF0;
      bad_count = 0;
      n_tests = 0;
      tick(20);
      rst_n <= 1'b1;
      tick(5);
      t_ident();
      t_cal();
      t_off();
      t_comm();
      t_stat();
      conclude();
   end
   initial begin
      tick(60000);
      bad_count++;
      $display("watchdog expired");
      conclude();
   end
endmodule // cscr_regs_tb
`default_nettype wire
